// File: include/rsp_pkg.sv
// shared constants and types for the serial register port
package rsp_pkg;
	// clock and timing
	localparam int unsigned SYS_CLK_HZ  = 10_000_000;
	localparam int unsigned TREC_US     = 1000;
	localparam int unsigned TREC_CYCLES = TREC_US * (SYS_CLK_HZ / 1_000_000);

	// bus addressing
	localparam logic [6:0] DEV_ADDR = 7'h68;
	localparam logic [7:0] ADDR_WR  = 8'hD0;
	localparam logic [7:0] ADDR_RD  = 8'hD1;

	// byte map
	localparam int unsigned BYTE_COUNT = 160;
	localparam logic [7:0] OFS_SUBSEC   = 8'h00;
	localparam logic [7:0] OFS_SECONDS  = 8'h01;
	localparam logic [7:0] OFS_MINUTES  = 8'h02;
	localparam logic [7:0] OFS_CENT_HRS = 8'h03;
	localparam logic [7:0] OFS_WEEKDAY  = 8'h04;
	localparam logic [7:0] OFS_DATE     = 8'h05;
	localparam logic [7:0] OFS_MONTH    = 8'h06;
	localparam logic [7:0] OFS_YEAR     = 8'h07;
	localparam logic [7:0] OFS_CONTROL  = 8'h08;
	localparam logic [7:0] OFS_WATCHDOG = 8'h09;
	localparam logic [7:0] OFS_ALARM    = 8'h0A;
	localparam logic [7:0] OFS_FLAG     = 8'h0F;
	localparam logic [7:0] OFS_RSVD_LO  = 8'h10;
	localparam logic [7:0] OFS_RSVD_LOE = 8'h12;
	localparam logic [7:0] OFS_SQWAVE   = 8'h13;
	localparam logic [7:0] OFS_TAMPER1  = 8'h14;
	localparam logic [7:0] OFS_TAMPER2  = 8'h15;
	localparam logic [7:0] OFS_ID_FIRST = 8'h16;
	localparam logic [7:0] OFS_ID_LAST  = 8'h1D;
	localparam logic [7:0] OFS_RSVD_HI  = 8'h1E;
	localparam logic [7:0] OFS_RSVD_HIE = 8'h1F;
	localparam logic [7:0] OFS_RAM_FST  = 8'h20;
	localparam logic [7:0] OFS_RAM_LAST = 8'h9F;
	localparam logic [7:0] PTR_RESET    = 8'h00;

	// write forwarding buffer
	localparam int unsigned FIFO_DEPTH = 16;

	// arbitrary identity value, no meaning
	localparam logic [63:0] UNIQUE_ID_DEF = 64'h0123456789ABCDEF;

	// link states
	typedef enum logic [4:0] {
		LNK_IDLE = 5'b00001,
		LNK_RX   = 5'b00010,
		LNK_ACK  = 5'b00100,
		LNK_TX   = 5'b01000,
		LNK_MACK = 5'b10000
	} rsp_state_t;

	// meaning of the byte being received
	typedef enum logic [2:0] {
		PH_ADDR = 3'b001,
		PH_OFFS = 3'b010,
		PH_DATA = 3'b100
	} rsp_phase_t;

	// one accepted byte write
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rsp_wr_t;
endpackage

// File: verilog/rsp_fifo.sv
// small fifo with registered output stage
`timescale 1ns/1ns
module rsp_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	// clocking
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	// depth must be a power of two of at least two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("rsp_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	logic             out_valid_r;
	logic [WIDTH-1:0] out_data_r;

	// status and handshake decode
	wire empty = (wptr_r == rptr_r);
	wire full  = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) && (wptr_r[AW] != rptr_r[AW]);
	wire push  = in_valid && !full;
	wire load  = !empty && (!out_valid_r || out_ready);
	assign in_ready  = !full;
	assign out_valid = out_valid_r;
	assign out_data  = out_data_r;

	// storage write
	always_ff @(posedge sys_clk) begin
		if (ce && push) begin
			mem_r[wptr_r[AW-1:0]] <= in_data;
		end
	end

	// pointers and output register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wptr_r      <= '0;
			rptr_r      <= '0;
			out_valid_r <= 1'b0;
			out_data_r  <= '0;
		end else if (ce) begin
			if (push)
				wptr_r <= wptr_r + 1'b1;
			if (load) begin
				rptr_r      <= rptr_r + 1'b1;
				out_data_r  <= mem_r[rptr_r[AW-1:0]];
				out_valid_r <= 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end
endmodule

// File: verilog/rsp_port.sv
// two-wire slave port onto the 160-byte clock and ram space
//
// Operation
// R1 - answer only bus address 68h (D0h/D1h)
// R2 - 160 bytes; clock, control, watchdog, alarm, flag
// R3 - square, tamper, serial number, user ram placement
// R4 - supply fail aborts access, resets pointer
// R5 - ignore bus while supply is low
// R6 - keep writes blocked for recovery time
// R7 - master starts only on idle bus
// R8 - data fall with clock high is start
// R9 - data rise with clock high is stop
// R10 - data stable during clock high
// R11 - bytes of eight bits plus acknowledge
// R12 - drive acknowledge low after received bytes
// R13 - release data on master no-acknowledge
// R14 - random read: offset write then read
// R15 - read pointer advances on acknowledge clock
// R16 - keep sending while master acknowledges
// R17 - hold clock copy while pointer at clock
// R18 - plain read starts at current pointer
// R19 - write stores bytes, pointer advances on acknowledge
// R20 - pointer wraps past last ram byte
`timescale 1ns/1ns
module rsp_port import rsp_pkg::*; #(
	parameter int unsigned  REC_CYCLES = TREC_CYCLES,
	parameter int unsigned  WR_DEPTH   = FIFO_DEPTH,
	parameter logic [63:0]  UNIQUE_ID  = UNIQUE_ID_DEF
) (
	// clocking
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// two-wire pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// supply monitor, high while below threshold
	input  wire logic        power_fail_threshold,
	// clock core side
	input  wire logic [63:0] live_time,
	output logic             time_hold,
	output logic             write_protect,
	output logic             core_wr_valid,
	input  wire logic        core_wr_ready,
	output rsp_wr_t          core_wr
);
	// recovery counter must fit its register
	if (REC_CYCLES < 1 || REC_CYCLES > 24'hFFFFFF) begin : g_bad_rec
		$error("rsp_port recovery count out of range");
	end

	// address classes
	function automatic logic is_clock(input logic [7:0] a);
		return a <= OFS_YEAR;
	endfunction

	function automatic logic is_ident(input logic [7:0] a);
		return a >= OFS_ID_FIRST && a <= OFS_ID_LAST;
	endfunction

	function automatic logic is_rsvd(input logic [7:0] a);
		return (a >= OFS_RSVD_LO && a <= OFS_RSVD_LOE) ||
		       (a >= OFS_RSVD_HI && a <= OFS_RSVD_HIE) || a > OFS_RAM_LAST;
	endfunction

	function automatic logic [7:0] next_ptr(input logic [7:0] a);
		return (a == OFS_RAM_LAST) ? PTR_RESET : a + 8'h01;
	endfunction

	// pin synchronisers, stage 0 feeds stage 1 only
	logic [2:0]  scl_s_r;
	logic [2:0]  sda_s_r;
	logic [2:0]  pf_s_r;
	logic        scl_f_r;
	logic        sda_f_r;
	logic        pf_f_r;

	// protocol state
	rsp_state_t  state_r;
	rsp_state_t  state_nxt;
	rsp_phase_t  phase_r;
	rsp_phase_t  phase_nxt;
	logic [3:0]  bit_cnt_r;
	logic [3:0]  bit_cnt_nxt;
	logic [7:0]  shift_r;
	logic [7:0]  shift_nxt;
	logic        rw_r;
	logic        rw_nxt;
	logic [7:0]  ptr_r;
	logic [7:0]  ptr_nxt;
	logic        sda_oe_r;
	logic        sda_oe_nxt;
	logic        do_write;
	logic [7:0]  rd_r;
	logic        hold_r;
	logic        wp_r;
	logic [23:0] rec_cnt_r;
	logic        sda_out_r;

	// byte space
	logic [7:0]  clk_r [8];
	logic [7:0]  mem_r [BYTE_COUNT];

	// filtered levels, taken as soon as stages agree to keep drive latency short
	wire scl_lvl  = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
	wire sda_lvl  = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
	wire scl_rise = scl_lvl && !scl_f_r;
	wire scl_fall = !scl_lvl && scl_f_r;
	wire start_ev = scl_lvl && scl_f_r && !sda_lvl && sda_f_r; // R8
	wire stop_ev  = scl_lvl && scl_f_r && sda_lvl && !sda_f_r; // R9
	wire addr_hit = (shift_r[7:1] == DEV_ADDR); // R1

	// write acceptance and forwarding
	logic    fifo_ready;
	rsp_wr_t wr_word;
	wire     ptr_writable = !is_ident(ptr_r) && !is_rsvd(ptr_r);
	wire     wr_push      = do_write && ptr_writable;
	assign wr_word.addr = ptr_r;
	assign wr_word.data = shift_r;

	// read data selection
	wire [5:0] id_sel  = 6'(ptr_r - OFS_ID_FIRST) << 3;
	wire [7:0] id_byte = UNIQUE_ID[id_sel +: 8];
	wire [7:0] rd_nxt  = is_clock(ptr_r) ? clk_r[ptr_r[2:0]] :
	                     is_ident(ptr_r) ? id_byte :
	                     is_rsvd(ptr_r)  ? 8'h00 : mem_r[ptr_r];

	// pin and core-side outputs
	assign sda_out       = sda_out_r;
	assign sda_oe        = sda_oe_r;
	assign time_hold     = hold_r;
	assign write_protect = wp_r;

	// three-stage sampling, level taken when stages agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			pf_s_r  <= 3'h0;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			pf_f_r  <= 1'b0;
		end else if (ce) begin
			scl_s_r <= {scl_s_r[1:0], scl_in};
			sda_s_r <= {sda_s_r[1:0], sda_in};
			pf_s_r  <= {pf_s_r[1:0], power_fail_threshold};
			scl_f_r <= scl_lvl;
			sda_f_r <= sda_lvl;
			if (pf_s_r[1] == pf_s_r[2])
				pf_f_r <= pf_s_r[2];
		end
	end

	// protocol next state
	always_comb begin
		state_nxt   = state_r;
		phase_nxt   = phase_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt   = shift_r;
		rw_nxt      = rw_r;
		ptr_nxt     = ptr_r;
		sda_oe_nxt  = sda_oe_r;
		do_write    = 1'b0;
		if (pf_f_r) begin
			state_nxt  = LNK_IDLE; // R4 R5
			ptr_nxt    = PTR_RESET; // R4
			sda_oe_nxt = 1'b0;
		end else if (start_ev) begin
			state_nxt   = LNK_RX; // R8 R14
			phase_nxt   = PH_ADDR;
			bit_cnt_nxt = 4'h0;
			sda_oe_nxt  = 1'b0;
		end else if (stop_ev) begin
			state_nxt  = LNK_IDLE; // R9 R16
			sda_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				LNK_RX: begin
					if (scl_rise && bit_cnt_r != 4'h8) begin
						shift_nxt   = {shift_r[6:0], sda_lvl}; // R10 R11
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						state_nxt  = LNK_ACK; // R12
						sda_oe_nxt = 1'b1;
						case (phase_r)
							PH_ADDR: begin
								rw_nxt = shift_r[0];
								if (!addr_hit) begin
									state_nxt  = LNK_IDLE; // R1
									sda_oe_nxt = 1'b0;
								end
							end
							PH_OFFS: begin
								ptr_nxt = is_rsvd(shift_r) && shift_r > OFS_RAM_LAST ? PTR_RESET : shift_r; // R14
							end
							PH_DATA: begin
								if (wp_r || !fifo_ready) begin
									state_nxt  = LNK_IDLE; // R6
									sda_oe_nxt = 1'b0;
								end else begin
									do_write = 1'b1; // R19
								end
							end
							default: begin
								state_nxt  = LNK_IDLE;
								sda_oe_nxt = 1'b0;
							end
						endcase
					end
				end
				LNK_ACK: begin
					if (scl_fall) begin
						bit_cnt_nxt = 4'h0;
						if (phase_r == PH_ADDR && rw_r) begin
							state_nxt  = LNK_TX; // R18
							shift_nxt  = rd_r;
							sda_oe_nxt = !rd_r[7];
						end else begin
							state_nxt  = LNK_RX;
							sda_oe_nxt = 1'b0;
							if (phase_r == PH_ADDR)
								phase_nxt = PH_OFFS;
							else if (phase_r == PH_OFFS)
								phase_nxt = PH_DATA;
							else
								ptr_nxt = next_ptr(ptr_r); // R19 R20
						end
					end
				end
				LNK_TX: begin
					if (scl_fall) begin
						bit_cnt_nxt = bit_cnt_r + 4'h1;
						shift_nxt   = {shift_r[6:0], 1'b0};
						sda_oe_nxt  = !shift_r[6]; // R10
						if (bit_cnt_r == 4'h7) begin
							state_nxt   = LNK_MACK;
							bit_cnt_nxt = 4'h0;
							sda_oe_nxt  = 1'b0; // R13
						end
					end
				end
				LNK_MACK: begin
					if (scl_rise) begin
						if (!sda_lvl) begin
							ptr_nxt     = next_ptr(ptr_r); // R15 R20
							bit_cnt_nxt = 4'h8;
						end else begin
							state_nxt = LNK_IDLE; // R13
						end
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						state_nxt   = LNK_TX; // R16
						shift_nxt   = rd_r;
						sda_oe_nxt  = !rd_r[7];
						bit_cnt_nxt = 4'h0;
					end
				end
				LNK_IDLE: begin
					sda_oe_nxt = 1'b0; // R7
				end
				default: begin
					state_nxt  = LNK_IDLE;
					sda_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// protocol registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r   <= LNK_IDLE;
			phase_r   <= PH_ADDR;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			rw_r      <= 1'b0;
			ptr_r     <= PTR_RESET;
			sda_oe_r  <= 1'b0;
			sda_out_r <= 1'b0;
			rd_r      <= 8'h00;
		end else if (ce) begin
			state_r   <= state_nxt;
			phase_r   <= phase_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r   <= shift_nxt;
			rw_r      <= rw_nxt;
			ptr_r     <= ptr_nxt;
			sda_oe_r  <= sda_oe_nxt;
			rd_r      <= rd_nxt; // R2 R3
		end
	end

	// hold time copy while a clock byte is addressed, from frame open until stop
	wire hold_nxt = !pf_f_r && !stop_ev && is_clock(ptr_nxt) && (state_nxt != LNK_IDLE || hold_r);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			hold_r <= 1'b0;
		else if (ce)
			hold_r <= hold_nxt; // R17
	end

	// supply recovery write lock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rec_cnt_r <= 24'(REC_CYCLES);
			wp_r      <= 1'b1;
		end else if (ce) begin
			if (pf_f_r)
				rec_cnt_r <= 24'(REC_CYCLES); // R6
			else if (rec_cnt_r != 24'h000000)
				rec_cnt_r <= rec_cnt_r - 24'h000001;
			wp_r <= pf_f_r || rec_cnt_r != 24'h000000; // R5 R6
		end
	end

	// user-visible clock bytes: live copy or bus write
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			for (int i = 0; i < 8; i++) begin
				if (wr_push && ptr_r == 8'(i))
					clk_r[i] <= shift_r; // R19
				else if (!hold_r)
					clk_r[i] <= live_time[8*i +: 8]; // R17
			end
		end
	end

	// control, alarm, flag, tamper and user ram bytes
	always_ff @(posedge sys_clk) begin
		if (ce && wr_push && !is_clock(ptr_r))
			mem_r[ptr_r] <= shift_r; // R2 R3 R19
	end

	// accepted writes forwarded to the clock core
	rsp_fifo #(
		.WIDTH ($bits(rsp_wr_t)),
		.DEPTH (WR_DEPTH)
	) u_wr_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (wr_push),
		.in_ready  (fifo_ready),
		.in_data   (wr_word),
		.out_valid (core_wr_valid),
		.out_ready (core_wr_ready),
		.out_data  (core_wr)
	);
endmodule

// File: tb/rsp_port_props.sv
// port checker for the serial register port
`timescale 1ns/1ns
module rsp_port_props import rsp_pkg::*; (
	// clocking
	input wire logic    sys_clk,
	input wire logic    rst,
	// pins
	input wire logic    scl_in,
	input wire logic    sda_in,
	input wire logic    sda_oe,
	input wire logic    power_fail_threshold,
	// core side
	input wire logic    time_hold,
	input wire logic    write_protect,
	input wire logic    core_wr_valid,
	input wire logic    core_wr_ready,
	input wire rsp_wr_t core_wr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// supply fail and recovery
	property p_wp_fail;
		$rose(power_fail_threshold) |-> ##[1:6] write_protect;
	endproperty
	a_wp_fail: assert property (p_wp_fail) else $error("no protect on supply fail");
	property p_wp_rec;
		$fell(power_fail_threshold) |-> write_protect [*8];
	endproperty
	a_wp_rec: assert property (p_wp_rec) else $error("protect dropped early");
	property p_wp_reset;
		$fell(rst) |-> write_protect;
	endproperty
	a_wp_reset: assert property (p_wp_reset) else $error("no protect after reset");
	property p_pf_quiet;
		power_fail_threshold [*6] |-> !sda_oe && !time_hold;
	endproperty
	a_pf_quiet: assert property (p_pf_quiet) else $error("bus active in supply fail");

	// link behaviour
	property p_ack_len;
		$rose(sda_oe) |-> sda_oe [*4];
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("drive too short");
	property p_stop_hold;
		scl_in && $rose(sda_in) |-> ##[1:8] !time_hold;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("hold kept after stop");

	// core write port
	property p_core_hold;
		core_wr_valid && !core_wr_ready |=> core_wr_valid && $stable(core_wr);
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("word changed while stalled");
	property p_core_addr;
		core_wr_valid |-> core_wr.addr <= OFS_RAM_LAST
			&& !(core_wr.addr inside {[OFS_RSVD_LO:OFS_RSVD_LOE], [OFS_ID_FIRST:OFS_RSVD_HIE]});
	endproperty
	a_core_addr: assert property (p_core_addr) else $error("write to fixed byte");
endmodule

bind rsp_port rsp_port_props rsp_port_props_inst (.sys_clk, .rst, .scl_in, .sda_in, .sda_oe,
	.power_fail_threshold, .time_hold, .write_protect, .core_wr_valid, .core_wr_ready, .core_wr);

// File: tb/rsp_master.sv
// two-wire bus master model
`timescale 1ns/1ns
module rsp_master (
	// bus lines
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// released bus at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// bit transfers, data moves only while clock low; long low phase covers slave drive latency
	task automatic bit_out(input logic b);
		#200 sda_low = !b;
		#300 scl = 1'b1;
		#300 scl = 1'b0;
	endtask
	task automatic bit_in(output logic b);
		#200 sda_low = 1'b0;
		#300 scl = 1'b1;
		#200 b = sda;
		#100 scl = 1'b0;
	endtask

	// frame edges, clock stands high between frames
	task automatic start;
		if (!scl) begin
			#200 sda_low = 1'b0;
			#300 scl = 1'b1;
		end
		#200 sda_low = 1'b1;
		#200 scl = 1'b0;
	endtask
	task automatic stop;
		#200 sda_low = 1'b1;
		#300 scl = 1'b1;
		#300 sda_low = 1'b0;
		#200;
	endtask

	// bytes, msb first, ninth bit is acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(b[i]);
		bit_in(a);
		ack = !a;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit_in(b[i]);
		bit_out(!ack);
	endtask
endmodule

// File: tb/rsp_port_tb_top.sv
// self-checking bench for the serial register port
`timescale 1ns/1ns
module rsp_port_tb_top import rsp_pkg::*;;
	localparam int unsigned REC = 600;
	logic        sys_clk, rst, power_fail_threshold, core_wr_ready;
	logic [63:0] live_time;
	logic        scl, sda_low, sda_in, sda_oe, time_hold, write_protect, core_wr_valid, ak;
	logic [7:0]  d;
	logic [7:0]  mem [0:159];
	rsp_wr_t     core_wr;
	rsp_wr_t     exp_q[$], got_q[$];
	int          ptr, n_errors, tests_run;

	// clock and wired data line with pull-up
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	assign sda_in = !(sda_oe || sda_low);

	rsp_port #(.REC_CYCLES(REC)) rsp_port_inst (.sys_clk, .rst, .ce(1'b1), .scl_in(scl), .sda_in, .sda_out(),
		.sda_oe, .power_fail_threshold, .live_time, .time_hold, .write_protect, .core_wr_valid,
		.core_wr_ready, .core_wr);
	rsp_master rsp_master_inst (.scl, .sda_low, .sda(sda_in));

	// collect words taken by the core
	always @(posedge sys_clk) if (core_wr_valid === 1'b1 && core_wr_ready) got_q.push_back(core_wr);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [7:0] expb(int p);
		return p < 8 ? live_time[8*p +: 8] : mem[p];
	endfunction
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wb(input logic [7:0] b, input logic e);
		rsp_master_inst.wbyte(b, ak);
		chk("ack", e, ak);
	endtask
	task automatic wait_words(int n);
		for (int k = 0; k < 200 && got_q.size() < n; k++) cyc(1);
		chk("words", n, got_q.size());
		while (got_q.size() > 0) chk("word", exp_q.pop_front(), got_q.pop_front());
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		power_fail_threshold = 1'b0;
		core_wr_ready = 1'b0;
		n_errors = 0;
		tests_run = 0;
		void'($urandom(34));
		live_time = {$urandom, $urandom};
		cyc(6);
		rst = 1'b0;
		cyc(10);
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			if (d[7:1] == DEV_ADDR) d[7] = ~d[7];
			rsp_master_inst.start();
			wb(d, 0);
			rsp_master_inst.stop();
		end
		cyc(REC);
		// fill the buffer while the core stalls, across the wrap
		rsp_master_inst.start();
		wb(ADDR_WR, 1);
		wb(8'h9A, 1);
		ptr = 'h9A;
		for (int i = 0; i < 18; i++) begin
			d = $urandom;
			wb(d, i < 17);
			if (i < 17) begin
				exp_q.push_back({ptr[7:0], d});
				mem[ptr] = d;
				ptr = (ptr + 1) % BYTE_COUNT;
			end
		end
		rsp_master_inst.stop();
		core_wr_ready = 1'b1;
		wait_words(17);
		// random read into the clock bytes
		rsp_master_inst.start();
		wb(ADDR_WR, 1);
		wb(8'h9C, 1);
		ptr = 'h9C;
		rsp_master_inst.start();
		wb(ADDR_RD, 1);
		for (int i = 0; i < 6; i++) begin
			rsp_master_inst.rbyte(i < 5, d);
			chk("read", expb(ptr), d);
			if (i < 5) ptr = (ptr + 1) % BYTE_COUNT;
		end
		chk("hold", 1, time_hold);
		rsp_master_inst.stop();
		cyc(10);
		chk("hold", 0, time_hold);
		// read from the held pointer
		rsp_master_inst.start();
		wb(ADDR_RD, 1);
		rsp_master_inst.rbyte(0, d);
		chk("read", expb(ptr), d);
		rsp_master_inst.stop();
		// supply fail in mid-write
		rsp_master_inst.start();
		wb(ADDR_WR, 1);
		wb(8'h30, 1);
		power_fail_threshold = 1'b1;
		cyc(20);
		chk("protect", 1, write_protect);
		rsp_master_inst.stop();
		power_fail_threshold = 1'b0;
		cyc(10);
		ptr = PTR_RESET;
		rsp_master_inst.start();
		wb(ADDR_RD, 1);
		rsp_master_inst.rbyte(0, d);
		chk("read", expb(ptr), d);
		rsp_master_inst.stop();
		// writes refused until recovery ends
		rsp_master_inst.start();
		wb(ADDR_WR, 1);
		wb(8'h40, 1);
		wb(8'h5A, 0);
		rsp_master_inst.stop();
		cyc(REC);
		rsp_master_inst.start();
		wb(ADDR_WR, 1);
		wb(8'h40, 1);
		d = $urandom;
		wb(d, 1);
		exp_q.push_back({8'h40, d});
		rsp_master_inst.stop();
		wait_words(1);
		give_verdict();
	end
endmodule
